// ===== tcsc_pkg.sv
package tcsc_pkg;
    // telegram layout
    localparam int TCSC_WORD_W = 8;
    localparam int TCSC_CODE_W = 5;
    localparam int TCSC_STANDBY_SELECT_POS = 5;
    localparam int TCSC_CODE_LSB = 0;
    localparam int TCSC_ZERO_HI = 7;
    localparam int TCSC_ZERO_LO = 6;
    // reset values of the held setting
    localparam logic [4:0] TCSC_CODE_RST = 5'h00;
    localparam logic TCSC_STANDBY_SELECT_RST = 1'b0;
    // link timing, in ns, and derived core cycles at 25 MHz
    localparam int TCSC_CORE_NS = 40;
    localparam int TCSC_ESU_NS = 20;
    localparam int TCSC_EOW_NS = 39;
    localparam int TCSC_ESU_CYC = (TCSC_ESU_NS + TCSC_CORE_NS - 1) / TCSC_CORE_NS;
    localparam int TCSC_EOW_CYC = (TCSC_EOW_NS + TCSC_CORE_NS - 1) / TCSC_CORE_NS;
    // master clock divider: half period of the shift clock in core cycles
    localparam int TCSC_HALF_CYC = 4;
endpackage

// ===== tcsc_if.sv
`timescale 1ns/1ps
interface tcsc_if;
    logic serial_latch_enable;
    logic shift_clk;
    logic serial_input_pin;
    modport master (output serial_latch_enable, output shift_clk, output serial_input_pin);
    modport device (input serial_latch_enable, input shift_clk, input serial_input_pin);
endinterface

// ===== tcsc_device.sv
`timescale 1ns/1ps
module tcsc_device
    import tcsc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    tcsc_if.device link,
    output logic [TCSC_CODE_W-1:0] o_tuning_code,
    output logic o_standby,
    output logic o_update
);
    ////////////////////////////////////////////////////////////////
    // three-stage synchronisers; only stages two and three are compared
    logic [2:0] en_sync_ff;
    logic [2:0] clk_sync_ff;
    logic [2:0] dat_sync_ff;
    logic en_lvl_ff;
    logic clk_lvl_ff;
    logic en_prev_ff;
    logic clk_prev_ff;
    logic [TCSC_WORD_W-1:0] shift_ff;
    logic clk_rise;
    logic en_fall;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_sync_ff <= 3'h0;
            clk_sync_ff <= 3'h0;
            dat_sync_ff <= 3'h0;
        end else begin
            en_sync_ff <= {en_sync_ff[1:0], link.serial_latch_enable};
            clk_sync_ff <= {clk_sync_ff[1:0], link.shift_clk};
            dat_sync_ff <= {dat_sync_ff[1:0], link.serial_input_pin};
        end
    end

    // filtered levels change only when stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_lvl_ff <= 1'b0;
            clk_lvl_ff <= 1'b0;
            en_prev_ff <= 1'b0;
            clk_prev_ff <= 1'b0;
        end else begin
            if (en_sync_ff[2] == en_sync_ff[1]) en_lvl_ff <= en_sync_ff[2];
            if (clk_sync_ff[2] == clk_sync_ff[1]) clk_lvl_ff <= clk_sync_ff[2];
            en_prev_ff <= en_lvl_ff;
            clk_prev_ff <= clk_lvl_ff;
        end
    end

    // clock edges count only inside our own frame
    assign clk_rise = clk_lvl_ff & ~clk_prev_ff & en_lvl_ff;
    assign en_fall = en_prev_ff & ~en_lvl_ff;

    ////////////////////////////////////////////////////////////////
    // shifter keeps the last eight bits; data is stable around the rise
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_ff <= '0;
        end else if (clk_rise) begin
            shift_ff <= {shift_ff[TCSC_WORD_W-2:0], dat_sync_ff[2]};
        end
    end

    // apply only on enable falling edge; bits 7,6 are ignored
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tuning_code <= TCSC_CODE_RST;
            o_standby <= TCSC_STANDBY_SELECT_RST;
            o_update <= 1'b0;
        end else begin
            o_update <= en_fall;
            if (en_fall) begin
                o_tuning_code <= shift_ff[TCSC_CODE_LSB +: TCSC_CODE_W];
                o_standby <= shift_ff[TCSC_STANDBY_SELECT_POS];
            end
        end
    end
endmodule

// ===== tcsc_master.sv
`timescale 1ns/1ps
module tcsc_master
    import tcsc_pkg::*;
#(
    parameter int HALF_CYC = TCSC_HALF_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_start,
    input wire logic [TCSC_CODE_W-1:0] i_tuning_code,
    input wire logic i_standby,
    output logic o_busy,
    tcsc_if.master link
);
    // the divider counter is eight bits wide, and edges shorter than two cycles are lost
    if (HALF_CYC < 2 || HALF_CYC > 255) begin : g_bad_half
        $error("HALF_CYC out of range");
    end

    typedef enum logic [2:0] {IDLE, SETUP, LOW, HIGH, HOLD, GAP} tcsc_state_t;
    tcsc_state_t state_ff;
    logic [7:0] cnt_ff;
    logic [2:0] bit_ff;
    logic [TCSC_WORD_W-1:0] word_ff;
    logic en_ff;
    logic sclk_ff;
    logic dat_ff;
    logic tick;

    assign tick = (cnt_ff == 8'(HALF_CYC - 1));
    assign o_busy = (state_ff != IDLE);
    assign link.serial_latch_enable = en_ff;
    assign link.shift_clk = sclk_ff;
    assign link.serial_input_pin = dat_ff;

    ////////////////////////////////////////////////////////////////
    // half-period divider
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) cnt_ff <= 8'h00;
        else if (state_ff == IDLE || tick) cnt_ff <= 8'h00;
        else cnt_ff <= cnt_ff + 8'h01;
    end

    // frame sequencer: enable high first, msb first, data moves on clock fall
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_ff <= IDLE;
            en_ff <= 1'b0;
            sclk_ff <= 1'b0;
            dat_ff <= 1'b0;
            bit_ff <= 3'h0;
            word_ff <= '0;
        end else begin
            case (state_ff)
                IDLE: begin
                    if (i_start) begin
                        word_ff <= {2'h0, i_standby, i_tuning_code};
                        en_ff <= 1'b1;
                        dat_ff <= 1'b0;
                        bit_ff <= 3'h7;
                        state_ff <= SETUP;
                    end
                end
                SETUP: if (tick) begin
                    dat_ff <= word_ff[TCSC_ZERO_HI];
                    state_ff <= LOW;
                end
                LOW: if (tick) begin
                    sclk_ff <= 1'b1;
                    state_ff <= HIGH;
                end
                HIGH: if (tick) begin
                    sclk_ff <= 1'b0;
                    if (bit_ff == 3'h0) begin
                        state_ff <= HOLD;
                    end else begin
                        bit_ff <= bit_ff - 3'h1;
                        dat_ff <= word_ff[bit_ff - 3'h1];
                        state_ff <= LOW;
                    end
                end
                HOLD: if (tick) begin
                    en_ff <= 1'b0;
                    state_ff <= GAP;
                end
                GAP: if (tick) state_ff <= IDLE;
                default: state_ff <= IDLE;
            endcase
        end
    end
endmodule

// ===== tcsc_props.sv
`timescale 1ns/1ps
module tcsc_props
    import tcsc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic serial_latch_enable,
    input wire logic shift_clk,
    input wire logic serial_input_pin,
    input wire logic [TCSC_CODE_W-1:0] o_tuning_code,
    input wire logic o_standby,
    input wire logic o_update
);
    logic [7:0] seen_ff;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////
    // shadow of the last eight framed bits, kept apart from the device
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) seen_ff <= 8'h00;
        else if (serial_latch_enable && $rose(shift_clk)) seen_ff <= {seen_ff[6:0], serial_input_pin};
    end
    // checks
    upd_after_fall_a: assert property ($fell(serial_latch_enable) |-> ##[1:8] o_update)
        else $error("no update");
    upd_pulse_a: assert property (o_update |=> !o_update)
        else $error("long update");
    hold_set_a: assert property (!o_update |-> $stable({o_standby, o_tuning_code}))
        else $error("setting moved");
    msb_first_a: assert property (o_update |-> {o_standby, o_tuning_code} == seen_ff[5:0])
        else $error("bad setting");
    top_zero_a: assert property ($fell(serial_latch_enable) |-> seen_ff[7:6] == 2'h0)
        else $error("top bits set");
    clk_framed_a: assert property ($rose(shift_clk) |-> serial_latch_enable)
        else $error("clock outside frame");
    en_first_a: assert property ($rose(serial_latch_enable) |-> !shift_clk [*2])
        else $error("clock early");
    data_fall_a: assert property (shift_clk |-> $stable(serial_input_pin))
        else $error("data moved");
    cover property (o_update && o_standby);
    cover property (o_update && o_tuning_code == 5'h1F);
    cover property ($fell(serial_latch_enable));
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb import tcsc_pkg::*;;
    logic clk = 0, rst_n = 0, start = 0, standby_select = 0, busy, du, ds, bu, bs;
    logic [4:0] code = 0, dc, bc;
    logic [7:0] nb = 0;
    logic [31:0] rng = 32'h55E9;
    logic [5:0] q[$];
    logic [5:0] edge_v[4] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
    int num_errors = 0, num_checks = 0, cyc = 0;
    tcsc_if link();
    tcsc_if link_b();
    tcsc_master u_tcsc_master (.i_core_clk(clk), .i_rst_n(rst_n), .i_start(start),
        .i_tuning_code(code), .i_standby(standby_select), .o_busy(busy), .link(link.master));
    tcsc_device u_tcsc_device (.i_core_clk(clk), .i_rst_n(rst_n), .link(link.device),
        .o_tuning_code(dc), .o_standby(ds), .o_update(du));
    tcsc_device u_tcsc_device_b (.i_core_clk(clk), .i_rst_n(rst_n), .link(link_b.device),
        .o_tuning_code(bc), .o_standby(bs), .o_update(bu));
    tcsc_props u_tcsc_props (.i_core_clk(clk), .i_rst_n(rst_n),
        .serial_latch_enable(link.serial_latch_enable), .shift_clk(link.shift_clk),
        .serial_input_pin(link.serial_input_pin), .o_tuning_code(dc), .o_standby(ds),
        .o_update(du));
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // start is left high while busy with other data: the master must ignore it
    task automatic send(input logic [5:0] v);
        q.push_back(v);
        start <= 1'b1;
        {standby_select, code} <= v;
        repeat (2) @(posedge clk);
        code <= ~v[4:0];
        @(posedge clk);
        start <= 1'b0;
        do @(negedge clk); while (busy !== 1'b0);
        @(posedge clk);
    endtask
    // bench-made link, 320 ns clock stepped on core edges; data moves with the clock fall
    task automatic raw(input logic [9:0] w, input logic en);
        link_b.serial_latch_enable <= en;
        link_b.serial_input_pin <= w[9];
        repeat (4) @(posedge clk);
        for (int i = 9; i >= 0; i--) begin
            link_b.shift_clk <= 1'b1;
            repeat (4) @(posedge clk);
            link_b.shift_clk <= 1'b0;
            if (i > 0) link_b.serial_input_pin <= w[i-1];
            repeat (4) @(posedge clk);
        end
        link_b.serial_latch_enable <= 1'b0;
        link_b.serial_input_pin <= ~w[0];
        repeat (10) @(posedge clk);
    endtask
    // clock, timeout and scoreboard
    initial forever #20 clk = ~clk;
    always @(posedge clk) if (++cyc == 20000) begin
        num_errors++;
        summarize();
    end
    always @(negedge clk) if (bu === 1'b1) nb <= nb + 8'h01;
    always @(negedge clk) if (du === 1'b1) chk("setting", {2'h0, q.pop_front()}, {2'h0, ds, dc});
    initial begin
        logic [31:0] r;
        {link_b.serial_latch_enable, link_b.shift_clk, link_b.serial_input_pin} = 3'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (edge_v[i]) send(edge_v[i]);
        repeat (30) begin
            r = rnd();
            send(r[5:0]);
        end
        repeat (10) @(posedge clk);
        chk("pending", 8'h00, 8'(q.size()));
        $display("test master done");
        raw(10'h2ED, 1'b1);
        chk("last eight", 8'h2D, {2'h0, bs, bc});
        raw(10'h155, 1'b0);
        chk("held", 8'h2D, {2'h0, bs, bc});
        chk("updates", 8'h01, nb);
        $display("test raw done");
        summarize();
    end
endmodule
